/* File: logic/cmof_regs.svh */
`ifndef CMOF_REGS_SVH
`define CMOF_REGS_SVH

// byte addresses of the register window (low address byte decoded)
`define CMOF_ADDR_STATUS   8'hE4
`define CMOF_ADDR_CTRL     8'hE8
`define CMOF_ADDR_PAGE     8'hEC
`define CMOF_ADDR_TAG      8'hF0
`define CMOF_ADDR_MASK     8'hF4
`define CMOF_ADDR_STAMP    8'hF8

// object count and page field
`define CMOF_NUM_OBJ       6
`define CMOF_PAGE_LSB      4
`define CMOF_PAGE_MSB      7

// tag and mask field positions
`define CMOF_STD_ID_LSB    21
`define CMOF_EXT_ID_LSB    3
`define CMOF_ID_MSB        31
`define CMOF_RTR_BIT       2
`define CMOF_RB1_BIT       1
`define CMOF_RB0_BIT       0
`define CMOF_IDE_MSK_BIT   0

// control register fields
`define CMOF_MODE_LSB      6
`define CMOF_MODE_MSB      7
`define CMOF_REPLY_BIT     5
`define CMOF_IDE_BIT       4
`define CMOF_ARMED_BIT     8

// status register fields
`define CMOF_RXDONE_LSB    0
`define CMOF_TXDONE_LSB    8

// reset values and time stamp prescale
`define CMOF_TAG_RESET     32'h00000000
`define CMOF_MASK_RESET    32'h00000000
`define CMOF_STAMP_DIV     8

`endif

/* File: logic/cmof_pkg.sv */
`include "cmof_regs.svh"

package cmof_pkg;

  localparam int NumObj = `CMOF_NUM_OBJ;

  // object communication modes
  typedef enum logic [1:0] {
    CMOF_DISABLE = 2'b00,
    CMOF_TX      = 2'b01,
    CMOF_RX      = 2'b10,
    CMOF_RXBUF   = 2'b11
  } cmof_mode_t;

  // bus slave state
  typedef struct packed {
    logic        wrPend;
    logic        rdPend;
    logic [7:0]  addr;
    logic        ready;
    logic        resp;
    logic [31:0] rdata;
  } cmof_ahb_state_t;

  // filter block state
  typedef struct packed {
    logic [NumObj-1:0][31:0] tag;
    logic [NumObj-1:0][31:0] mask;
    logic [NumObj-1:0][1:0]  mode;
    logic [NumObj-1:0]       replyValid;
    logic [NumObj-1:0]       ide;
    logic [NumObj-1:0]       armed;
    logic [NumObj-1:0]       rxDone;
    logic [NumObj-1:0]       txDone;
    logic [3:0]              page;
    logic [15:0]             stamp;
    logic [15:0]             divCnt;
    logic                    rxAccept;
    logic [2:0]              rxObj;
    logic                    txValid;
    logic [2:0]              txObj;
    logic [28:0]             txId;
    logic                    txRtr;
    logic                    txIde;
    logic                    txRb1;
    logic                    txRb0;
  } cmof_state_t;

endpackage

/* File: logic/cmof_accept_filter.sv */
`timescale 1ns/1ns
`include "cmof_regs.svh"

module cmof_accept_filter
  import cmof_pkg::*;
(
  input  wire logic [31:0] tag,
  input  wire logic [31:0] mask,
  input  wire logic        objIde,
  input  wire logic [28:0] rxId,
  input  wire logic        rxRtr,
  input  wire logic        rxIde,
  output logic             hit
);

  logic [31:0] rxWord;
  logic [31:0] layout;
  logic [31:0] bitOk;
  logic        ideOk;

  // received fields placed in the object's own layout
  assign rxWord = objIde ? {rxId, rxRtr, 2'b00} : {rxId[10:0], 18'h00000, rxRtr, 2'b00};
  assign layout = objIde ? 32'hFFFFFFFC : 32'hFFE00004;

  // per bit: mask 0 forces true, mask 1 demands equality
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      if (i < `CMOF_RTR_BIT) begin : g_res
        assign bitOk[i] = 1'b1;
      end else begin : g_cmp
        assign bitOk[i] = ~(mask[i] & layout[i]) | (rxWord[i] == tag[i]);
      end
    end
  endgenerate

  assign ideOk = ~mask[`CMOF_IDE_MSK_BIT] | (rxIde == objIde);
  assign hit   = (&bitOk) & ideOk;

endmodule

/* File: logic/cmof_ahb_slave.sv */
`timescale 1ns/1ns

module cmof_ahb_slave
  import cmof_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] rdData,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [7:0]       regAddr,
  output logic             regWrite
);

  cmof_ahb_state_t st;
  cmof_ahb_state_t next_st;
  logic            take;

  // only word transfers are taken; others complete with no effect
  assign take = hsel & hready & htrans[1] & (hsize == 3'h2);

  // reads take one wait state so a write just ahead is already stored
  always_comb begin
    next_st        = st;
    next_st.wrPend = take & hwrite;
    if (st.rdPend) begin
      next_st.rdata  = rdData;
      next_st.ready  = 1'b1;
      next_st.rdPend = 1'b0;
    end else if (take & ~hwrite) begin
      next_st.rdPend = 1'b1;
      next_st.ready  = 1'b0;
    end
    if (take) begin
      next_st.addr = haddr[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '{wrPend: 1'b0, rdPend: 1'b0, addr: 8'h00, ready: 1'b1, resp: 1'b0, rdata: 32'h00000000};
    end else begin
      st <= next_st;
    end
  end

  assign hrdata    = st.rdata;
  assign hreadyout = st.ready;
  assign hresp     = st.resp;
  assign regAddr   = st.addr;
  assign regWrite  = st.wrPend;

  chk_read_wait_state: assert property (@(posedge clock) disable iff (reset)
    (take & ~hwrite) |=> !hreadyout ##1 hreadyout) else $error("read did not take exactly one wait state");

endmodule

/* File: logic/cmof_top.sv */
// Operation
// - standard identifier sits in tag bits 31..21
// - extended identifier sits in tag bits 31..3
// - send tag identifier, received identifier overwrites it
// - tag bit 2 is sent and loaded RTR
// - auto reply clears RTR tag before replying
// - tag bits 0/1 carry RB0, RB1 extended only
// - mask 0 forces match, 1 compares bit
// - mask identifier bits align with tag layout
// - mask bit 2 gates RTR comparison
// - mask bit 0 gates extension bit comparison
// - read-only 16-bit free-running time stamp counter
// - tag and mask follow page, objects 0..5
// - extension bit selects standard or extended layout
//
// Decided for this implementation: the AHB-Lite interface to the registers.

`timescale 1ns/1ns
`include "cmof_regs.svh"

module cmof_top
  import cmof_pkg::*;
#(
  parameter int StampDiv = `CMOF_STAMP_DIV
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rxFrameValid,
  input  wire logic [28:0] rxIdIn,
  input  wire logic        rxRtrIn,
  input  wire logic        rxIdeIn,
  input  wire logic        rxRb1In,
  input  wire logic        rxRb0In,
  input  wire logic        txGrant,
  input  wire logic        txFinish,
  output logic             rxAccept,
  output logic [2:0]       rxObject,
  output logic             txValid,
  output logic [2:0]       txObject,
  output logic [28:0]      txId,
  output logic             txRtr,
  output logic             txIde,
  output logic             txRb1,
  output logic             txRb0
);

  cmof_state_t       st;
  cmof_state_t       next_st;
  logic [7:0]        regAddr;
  logic              regWrite;
  logic [31:0]       rdData;
  logic [NumObj-1:0] rawHit;
  logic [NumObj-1:0] hitVec;
  logic [NumObj-1:0] txCand;
  logic              pageOk;
  logic [2:0]        pIdx;
  logic              stampTick;

  // register bus front end
  cmof_ahb_slave u_bus (
    .clock     (clock),
    .reset     (reset),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .rdData    (rdData),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .regAddr   (regAddr),
    .regWrite  (regWrite)
  );

  // one acceptance filter per object, qualified by its mode
  genvar g;
  generate
    for (g = 0; g < NumObj; g++) begin : g_obj
      cmof_accept_filter u_filt (
        .tag    (st.tag[g]),
        .mask   (st.mask[g]),
        .objIde (st.ide[g]),
        .rxId   (rxIdIn),
        .rxRtr  (rxRtrIn),
        .rxIde  (rxIdeIn),
        .hit    (rawHit[g])
      );
      assign hitVec[g] = rawHit[g] & st.armed[g] & st.mode[g][1];
      assign txCand[g] = st.armed[g] & (st.mode[g] == CMOF_TX);
    end
  endgenerate

  // page beyond the last object reaches nothing
  assign pageOk    = st.page < 4'(NumObj);
  assign pIdx      = st.page[2:0];
  assign stampTick = st.divCnt == 16'(StampDiv - 1);

  // read decode, unmapped addresses read as zero
  always_comb begin
    rdData = 32'h00000000;
    unique case (regAddr)
      `CMOF_ADDR_STATUS: begin
        rdData[`CMOF_RXDONE_LSB +: NumObj] = st.rxDone;
        rdData[`CMOF_TXDONE_LSB +: NumObj] = st.txDone;
      end
      `CMOF_ADDR_CTRL: begin
        if (pageOk) begin
          rdData[`CMOF_MODE_MSB:`CMOF_MODE_LSB] = st.mode[pIdx];
          rdData[`CMOF_REPLY_BIT]               = st.replyValid[pIdx];
          rdData[`CMOF_IDE_BIT]                 = st.ide[pIdx];
          rdData[`CMOF_ARMED_BIT]               = st.armed[pIdx];
        end
      end
      `CMOF_ADDR_PAGE:  rdData[`CMOF_PAGE_MSB:`CMOF_PAGE_LSB] = st.page;
      `CMOF_ADDR_TAG:   rdData = pageOk ? st.tag[pIdx] : 32'h00000000;
      `CMOF_ADDR_MASK:  rdData = pageOk ? st.mask[pIdx] : 32'h00000000;
      `CMOF_ADDR_STAMP: rdData = {16'h0000, st.stamp};
      default:          rdData = 32'h00000000;
    endcase
  end

  // next state: bus writes first, then hardware events so they win
  always_comb begin
    int sel;
    int tsel;
    sel              = NumObj;
    tsel             = NumObj;
    next_st          = st;
    next_st.rxAccept = 1'b0;
    next_st.txValid  = 1'b0;

    // time stamp prescaler and counter, wraps at full range
    if (stampTick) begin
      next_st.divCnt = 16'h0000;
      next_st.stamp  = st.stamp + 16'h0001;
    end else begin
      next_st.divCnt = st.divCnt + 16'h0001;
    end

    // software writes; tag and mask go to the paged object only
    if (regWrite) begin
      unique case (regAddr)
        `CMOF_ADDR_STATUS: begin
          next_st.rxDone = st.rxDone & ~hwdata[`CMOF_RXDONE_LSB +: NumObj];
          next_st.txDone = st.txDone & ~hwdata[`CMOF_TXDONE_LSB +: NumObj];
        end
        `CMOF_ADDR_CTRL: begin
          if (pageOk) begin
            next_st.mode[pIdx]       = hwdata[`CMOF_MODE_MSB:`CMOF_MODE_LSB];
            next_st.replyValid[pIdx] = hwdata[`CMOF_REPLY_BIT];
            next_st.ide[pIdx]        = hwdata[`CMOF_IDE_BIT];
            next_st.armed[pIdx]      = |hwdata[`CMOF_MODE_MSB:`CMOF_MODE_LSB];
          end
        end
        `CMOF_ADDR_PAGE: next_st.page = hwdata[`CMOF_PAGE_MSB:`CMOF_PAGE_LSB];
        `CMOF_ADDR_TAG: begin
          if (pageOk) begin
            next_st.tag[pIdx] = hwdata;
          end
        end
        `CMOF_ADDR_MASK: begin
          if (pageOk) begin
            next_st.mask[pIdx] = hwdata;
          end
        end
        default: begin
        end
      endcase
    end

    // lowest index wins among several hits
    for (int i = NumObj - 1; i >= 0; i--) begin
      if (hitVec[i]) begin
        sel = i;
      end
      if (txCand[i]) begin
        tsel = i;
      end
    end

    // reception overwrites identifier, RTR, RB0 and extension, and RB1 for extended frames only
    if (rxFrameValid && sel < NumObj) begin
      if (rxIdeIn) begin
        next_st.tag[sel][`CMOF_ID_MSB:`CMOF_EXT_ID_LSB] = rxIdIn;
        next_st.tag[sel][`CMOF_RB1_BIT]                 = rxRb1In;
      end else begin
        next_st.tag[sel][`CMOF_ID_MSB:`CMOF_STD_ID_LSB] = rxIdIn[10:0];
      end
      next_st.tag[sel][`CMOF_RTR_BIT] = rxRtrIn;
      next_st.tag[sel][`CMOF_RB0_BIT] = rxRb0In;
      next_st.ide[sel]                = rxIdeIn;
      next_st.rxDone[sel]             = 1'b1;
      next_st.rxAccept                = 1'b1;
      next_st.rxObj                   = 3'(sel);
      // a remote frame on a ready reply object turns it into a data producer
      if (rxRtrIn && st.replyValid[sel]) begin
        next_st.tag[sel][`CMOF_RTR_BIT] = 1'b0;
        next_st.mode[sel]               = CMOF_TX;
        next_st.replyValid[sel]         = 1'b0;
      end else begin
        next_st.armed[sel] = 1'b0;
      end
    end

    // hand the lowest producer's fields to the frame engine
    if (txGrant && tsel < NumObj) begin
      next_st.txValid = 1'b1;
      next_st.txObj   = 3'(tsel);
      next_st.txIde   = st.ide[tsel];
      next_st.txRtr   = st.tag[tsel][`CMOF_RTR_BIT];
      next_st.txRb0   = st.tag[tsel][`CMOF_RB0_BIT];
      if (st.ide[tsel]) begin
        next_st.txId  = st.tag[tsel][`CMOF_ID_MSB:`CMOF_EXT_ID_LSB];
        next_st.txRb1 = st.tag[tsel][`CMOF_RB1_BIT];
      end else begin
        next_st.txId  = {18'h00000, st.tag[tsel][`CMOF_ID_MSB:`CMOF_STD_ID_LSB]};
        next_st.txRb1 = 1'b0;
      end
    end

    // completion disarms the object; flag set after any clear above
    if (txFinish && st.txObj < 3'(NumObj)) begin
      next_st.armed[st.txObj]  = 1'b0;
      next_st.txDone[st.txObj] = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '0;
      for (int i = 0; i < NumObj; i++) begin
        st.tag[i]  <= `CMOF_TAG_RESET;
        st.mask[i] <= `CMOF_MASK_RESET;
      end
    end else begin
      st <= next_st;
    end
  end

  // every output comes straight from the state register
  assign rxAccept = st.rxAccept;
  assign rxObject = st.rxObj;
  assign txValid  = st.txValid;
  assign txObject = st.txObj;
  assign txId     = st.txId;
  assign txRtr    = st.txRtr;
  assign txIde    = st.txIde;
  assign txRb1    = st.txRb1;
  assign txRb0    = st.txRb0;

  chk_stamp_advance: assert property (@(posedge clock) disable iff (reset)
    stampTick |=> st.stamp == $past(st.stamp) + 16'h0001) else $error("time stamp did not advance on tick");

  chk_stamp_hold: assert property (@(posedge clock) disable iff (reset)
    !stampTick |=> $stable(st.stamp)) else $error("time stamp moved without tick");

  chk_std_tag_load: assert property (@(posedge clock) disable iff (reset)
    rxAccept && !st.ide[rxObject] |->
      st.tag[rxObject][31:21] == $past(rxIdIn[10:0])) else $error("standard id not loaded into tag");

  chk_ext_tag_load: assert property (@(posedge clock) disable iff (reset)
    rxAccept && st.ide[rxObject] |->
      st.tag[rxObject][31:3] == $past(rxIdIn)) else $error("extended id not loaded into tag");

  chk_reply_rtr_clear: assert property (@(posedge clock) disable iff (reset)
    rxAccept && st.mode[rxObject] == CMOF_TX |->
      !st.tag[rxObject][2] && $past(rxRtrIn)) else $error("reply object kept remote request bit");

  chk_std_tx_fields: assert property (@(posedge clock) disable iff (reset)
    txValid && !txIde |-> txId[28:11] == 18'h00000 && !txRb1) else $error("standard frame carries extended bits");

  // index as chosen at the grant; txObject itself moves on the same edge
  chk_tx_rtr_source: assert property (@(posedge clock) disable iff (reset)
    txValid |-> txRtr == $past(st.tag[next_st.txObj][`CMOF_RTR_BIT]))
    else $error("sent RTR differs from tag bit 2");

  chk_no_hit_reject: assert property (@(posedge clock) disable iff (reset)
    rxFrameValid && hitVec == '0 |=> !rxAccept) else $error("frame accepted without a matching object");

  chk_page_guard: assert property (@(posedge clock) disable iff (reset)
    regWrite && !pageOk && !rxFrameValid |=> $stable(st.tag) && $stable(st.mask))
    else $error("write to absent object changed storage");

  chk_hit_accept: assert property (@(posedge clock) disable iff (reset)
    rxFrameValid && hitVec != '0 |=> rxAccept) else $error("matching frame was not accepted");

  chk_rtr_tag_load: assert property (@(posedge clock) disable iff (reset)
    rxAccept && st.mode[rxObject] != CMOF_TX |->
      st.tag[rxObject][`CMOF_RTR_BIT] == $past(rxRtrIn)) else $error("received RTR not loaded into tag");

  chk_no_producer: assert property (@(posedge clock) disable iff (reset)
    txGrant && txCand == '0 |=> !txValid) else $error("transmit offered with no armed producer");

  chk_ext_tx_id: assert property (@(posedge clock) disable iff (reset)
    txValid && txIde |->
      txId == $past(st.tag[next_st.txObj][`CMOF_ID_MSB:`CMOF_EXT_ID_LSB]))
    else $error("extended id differs from tag");

endmodule

/* File: test/cmof_can_node.sv */
`timescale 1ns/1ns

// behavioural frame engine standing in for the other nodes on the bus
module cmof_can_node (
  input  wire logic        clock,
  input  wire logic        rxAccept,
  input  wire logic [2:0]  rxObject,
  input  wire logic        txValid,
  output logic             rxFrameValid,
  output logic [28:0]      rxIdIn,
  output logic             rxRtrIn,
  output logic             rxIdeIn,
  output logic             rxRb1In,
  output logic             rxRb0In,
  output logic             txGrant,
  output logic             txFinish
);
  // quiet bus at time zero
  initial begin
    rxFrameValid = 1'b0;
    rxIdIn = 29'h0;
    {rxRtrIn, rxIdeIn, rxRb1In, rxRb0In} = 4'h0;
    txGrant = 1'b0;
    txFinish = 1'b0;
  end

  // one received frame, bits = {rtr, ide, rb1, rb0}
  // fields flip afterwards so a stale value never passes for a valid one
  task automatic send(input logic [28:0] id, input logic [3:0] bits, output logic hit, output logic [2:0] obj);
    @(posedge clock);
    rxFrameValid <= 1'b1;
    rxIdIn <= id;
    {rxRtrIn, rxIdeIn, rxRb1In, rxRb0In} <= bits;
    @(posedge clock);
    rxFrameValid <= 1'b0;
    rxIdIn <= ~id;
    {rxRtrIn, rxIdeIn, rxRb1In, rxRb0In} <= ~bits;
    #1 hit = rxAccept;
    obj = rxObject;
  endtask

  // offer one transmit slot; report whether a producer answered
  task automatic grant(output logic seen);
    @(posedge clock);
    txGrant <= 1'b1;
    @(posedge clock);
    txGrant <= 1'b0;
    #1 seen = txValid;
  endtask

  // frame of the last handed-out object went out fine
  task automatic finish();
    @(posedge clock);
    txFinish <= 1'b1;
    @(posedge clock);
    txFinish <= 1'b0;
  endtask
endmodule

/* File: test/cmof_top_bench.sv */
`timescale 1ns/1ns
`include "cmof_regs.svh"

module cmof_top_bench
  import cmof_pkg::*;
;
  logic        clock, reset, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, rxObject, txObject;
  logic        rxFrameValid, rxRtrIn, rxIdeIn, rxRb1In, rxRb0In, txGrant, txFinish;
  logic [28:0] rxIdIn, txId;
  logic        rxAccept, txValid, txRtr, txIde, txRb1, txRb0;
  int          numErrors, nTests;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // divider of 2 so the stamp also holds between ticks; stamp spans below are even
  cmof_top #(.StampDiv(2)) cmof_top_inst (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxFrameValid(rxFrameValid), .rxIdIn(rxIdIn), .rxRtrIn(rxRtrIn),
    .rxIdeIn(rxIdeIn), .rxRb1In(rxRb1In), .rxRb0In(rxRb0In), .txGrant(txGrant), .txFinish(txFinish),
    .rxAccept(rxAccept), .rxObject(rxObject), .txValid(txValid), .txObject(txObject), .txId(txId),
    .txRtr(txRtr), .txIde(txIde), .txRb1(txRb1), .txRb0(txRb0));

  cmof_can_node cmof_can_node_inst (.clock(clock), .rxAccept(rxAccept), .rxObject(rxObject),
    .txValid(txValid), .rxFrameValid(rxFrameValid), .rxIdIn(rxIdIn), .rxRtrIn(rxRtrIn), .rxIdeIn(rxIdeIn),
    .rxRb1In(rxRb1In), .rxRb0In(rxRb0In), .txGrant(txGrant), .txFinish(txFinish));

  always #20 clock = ~clock;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one single word transfer; no fixed latency assumed, only hready counts
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] junk;
    bus(1'b1, a, d, junk);
  endtask

  task automatic r(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, exp);
  endtask

  // frame in; expect {hit, object} with object only meaningful on a hit
  task automatic rx(input logic [28:0] id, input logic [3:0] bits, input logic [3:0] e);
    logic       h;
    logic [2:0] o;
    cmof_can_node_inst.send(id, bits, h, o);
    chk({h, h ? o : 3'h0}, e);
  endtask

  task automatic t_map();
    r(`CMOF_ADDR_TAG, `CMOF_TAG_RESET);
    r(`CMOF_ADDR_MASK, `CMOF_MASK_RESET);
    w(`CMOF_ADDR_PAGE, 32'h50);
    w(`CMOF_ADDR_TAG, 32'hA5A5A5A7);
    w(`CMOF_ADDR_MASK, 32'h5A5A5A5B);
    r(`CMOF_ADDR_TAG, 32'hA5A5A5A7);
    r(`CMOF_ADDR_MASK, 32'h5A5A5A5B);
    w(`CMOF_ADDR_PAGE, 32'h40);
    r(`CMOF_ADDR_TAG, 32'h0);
    w(`CMOF_ADDR_PAGE, 32'h60);
    w(`CMOF_ADDR_TAG, 32'hFFFFFFFF);
    r(`CMOF_ADDR_TAG, 32'h0);
    r(8'hFC, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // standard layout: rb1 in the tag must not reach the wire
  task automatic t_tx_std();
    logic s;
    w(`CMOF_ADDR_PAGE, 32'h00);
    w(`CMOF_ADDR_TAG, 32'hB4600007);
    w(`CMOF_ADDR_CTRL, 32'h40);
    cmof_can_node_inst.grant(s);
    chk({31'h0, s}, 32'h1);
    chk({txObject, txId}, {3'h0, 29'h000005A3});
    chk({txRtr, txIde, txRb1, txRb0}, 4'h9);
    cmof_can_node_inst.finish();
    r(`CMOF_ADDR_CTRL, 32'h40);
    r(`CMOF_ADDR_STATUS, 32'h100);
  endtask

  task automatic t_tx_ext();
    logic s;
    w(`CMOF_ADDR_PAGE, 32'h10);
    w(`CMOF_ADDR_TAG, 32'hD5E6F7AB);
    w(`CMOF_ADDR_CTRL, 32'h50);
    cmof_can_node_inst.grant(s);
    chk({31'h0, s}, 32'h1);
    chk({txObject, txId}, {3'h1, 29'h1ABCDEF5});
    chk({txRtr, txIde, txRb1, txRb0}, 4'h7);
    cmof_can_node_inst.finish();
    cmof_can_node_inst.grant(s);
    chk({31'h0, s}, 32'h0);
  endtask

  // mask low id nibble off, compare rtr and ide, then release those two
  task automatic t_rx();
    w(`CMOF_ADDR_PAGE, 32'h20);
    w(`CMOF_ADDR_TAG, 32'h24600000);
    w(`CMOF_ADDR_MASK, 32'hFE000005);
    w(`CMOF_ADDR_CTRL, 32'h80);
    rx(29'h12F, 4'h3, 4'hA);
    r(`CMOF_ADDR_TAG, 32'h25E00001);
    rx(29'h12F, 4'h3, 4'h0);
    w(`CMOF_ADDR_CTRL, 32'h80);
    rx(29'h02F, 4'h0, 4'h0);
    rx(29'h12F, 4'h8, 4'h0);
    rx(29'h12F, 4'h4, 4'h0);
    w(`CMOF_ADDR_MASK, 32'hFE000000);
    rx(29'h12F, 4'h8, 4'hA);
    r(`CMOF_ADDR_TAG, 32'h25E00004);
  endtask

  task automatic t_reply();
    logic s;
    w(`CMOF_ADDR_PAGE, 32'h30);
    w(`CMOF_ADDR_TAG, 32'h0AA00000);
    w(`CMOF_ADDR_MASK, 32'hFFE00000);
    w(`CMOF_ADDR_CTRL, 32'hA0);
    rx(29'h055, 4'h8, 4'hB);
    r(`CMOF_ADDR_TAG, 32'h0AA00000);
    r(`CMOF_ADDR_CTRL, 32'h140);
    cmof_can_node_inst.grant(s);
    chk({txObject, txId}, {3'h3, 29'h055});
    chk({31'h0, txRtr}, 32'h0);
    cmof_can_node_inst.finish();
  endtask

  // reads 4 clocks apart, write plus one idle clock spans 8; divider 2 halves both
  // a taken write to the read-only stamp would break the second span
  task automatic t_stamp();
    logic [31:0] a, b, c;
    bus(1'b0, `CMOF_ADDR_STAMP, 32'h0, a);
    bus(1'b0, `CMOF_ADDR_STAMP, 32'h0, b);
    chk({16'h0, b[15:0] - a[15:0]}, 32'h2);
    chk(b & 32'hFFFF0000, 32'h0);
    w(`CMOF_ADDR_STAMP, 32'h0);
    @(posedge clock);
    bus(1'b0, `CMOF_ADDR_STAMP, 32'h0, c);
    chk({16'h0, c[15:0] - b[15:0]}, 32'h4);
  endtask

  task automatic stopTest();
    $display("checks %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    numErrors = 0;
    nTests = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    t_map();
    t_tx_std();
    t_tx_ext();
    t_rx();
    t_reply();
    t_stamp();
    stopTest();
  end

  // the whole run needs well under 1000 clocks
  initial begin
    #(40 * 5000);
    numErrors++;
    stopTest();
  end
endmodule
